/* File: verilog/dhrp_regs.svh */
`ifndef DHRP_REGS_SVH
`define DHRP_REGS_SVH
// host register address fields
`define DHRP_A3_BIT 3
`define DHRP_A0_BIT 0
`define DHRP_GEN_SEL 4'h8
// mode register fields
`define DHRP_MODE_RELOAD 7
`define DHRP_MODE_STOP 6
`define DHRP_MODE_EARLY 5
`define DHRP_MODE_CIRC 4
`define DHRP_MODE_RESET 8'h00
// status register fields
`define DHRP_STAT_PEND 4
// count register cycle type field
`define DHRP_CNT_TYPE_HI 15
`define DHRP_CNT_TYPE_LO 14
`define DHRP_CNT_FIELD_W 14
// controller register offsets (avalon byte addresses)
`define DHRP_CSR_CMD 8'h00
`define DHRP_CSR_ADDR 8'h04
`define DHRP_CSR_WDATA 8'h08
`define DHRP_CSR_RDATA 8'h0C
`define DHRP_CSR_STATE 8'h10
// command register fields
`define DHRP_CMD_GO 0
`define DHRP_CMD_WR 1
`endif

/* File: verilog/dhrp_pkg.sv */
package dhrp_pkg;
	typedef logic [7:0] dhrp_byte_t;
	typedef logic [3:0] dhrp_addr_t;
	typedef enum logic [1:0] {DHRP_VERIFY = 2'b00, DHRP_WRITE = 2'b01,
		DHRP_READ = 2'b10} dhrp_cycle_t;
	typedef enum logic [1:0] {DHRP_H_IDLE, DHRP_H_SETUP, DHRP_H_STROBE,
		DHRP_H_HOLD} dhrp_hstate_t;
endpackage : dhrp_pkg

/* File: verilog/dhrp_if.sv */
interface dhrp_if;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rdata_oe;
	modport device (input cs_n, rd_n, wr_n, addr, wdata, output rdata, rdata_oe);
	modport host (output cs_n, rd_n, wr_n, addr, wdata, input rdata, rdata_oe);
endinterface : dhrp_if

/* File: verilog/dhrp_status.sv */
`include "dhrp_regs.svh"
module dhrp_status #(
	parameter int NCH = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [NCH-1:0] count_done,
	input wire logic status_read_end,
	input wire logic reload_start,
	input wire logic reload_finish,
	input wire logic mode_write,
	input wire logic mode_reload_bit,
	output logic [NCH-1:0] count_done_flags,
	output logic reload_pending
);
	import dhrp_pkg::*;

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			count_done_flags <= '0;
		end else begin
			// set wins over a clearing read
			count_done_flags <= (status_read_end ? '0 : count_done_flags) | count_done; // see [R1] see [R2]
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			reload_pending <= 1'b0;
		end else if (reload_start) begin
			reload_pending <= 1'b1;
		end else if (reload_finish || (mode_write && !mode_reload_bit)) begin
			reload_pending <= 1'b0; // see [R4] see [R3]
		end
	end
endmodule : dhrp_status

/* File: verilog/dhrp_device.sv */
// The implementer's own choices: the placing of the registers and the Avalon-MM register port.
`include "dhrp_regs.svh"
// Function
// [R1] count done sets channel status flag
// [R2] flags stay until status read or reset
// [R3] status read leaves reload pending alone
// [R4] pending clears: reset, reload off, update done
// [R5] host waits for pending before channel 3
// [R6] status: zeros, pending, four done flags
// [R7] mode: reload, stop, early, circular, enables
// [R8] four channels, address and count registers
// [R9] select low plus strobe reads or writes
// [R10] A3 picks channel or mode/status
// [R11] A0 address/count, A2..A1 channel number
// [R12] byte pointer toggles after channel access
// [R13] pointer cleared by reset, mode write
// [R14] host accesses pairs, low byte first
// [R15] host keeps select steady during strobes
// [R16] host keeps pairs uninterrupted
// [R17] host inhibits transfers before reenabling
// [R18] count top bits give cycle type
// [R19] host loads count minus one
// [R20] low byte holds bits seven to zero
module dhrp_device #(
	parameter int NCH = 4
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// host register port
	dhrp_if.device BUS,
	// channel engine side
	input wire logic [NCH-1:0] COUNT_DONE,
	input wire logic RELOAD_START,
	input wire logic RELOAD_FINISH,
	output dhrp_pkg::dhrp_byte_t MODE,
	output logic [NCH*16-1:0] XFER_ADDRESS,
	output logic [NCH*16-1:0] XFER_COUNT,
	output logic [NCH*2-1:0] CYCLE_TYPE,
	output logic [NCH-1:0] COUNT_DONE_FLAGS,
	output logic RELOAD_PENDING
);
	import dhrp_pkg::*;

	logic [15:0] xfer_address [NCH];
	logic [15:0] xfer_count [NCH];
	logic byte_ptr;
	logic rd_q;
	logic wr_q;
	logic [3:0] addr_q;
	logic rd_act;
	logic wr_act;
	logic rd_end;
	logic wr_end;
	logic is_gen;
	logic addr_wr;
	logic cnt_wr;
	logic [1:0] chan;
	logic [NCH-1:0] done_flags;
	logic pending;
	dhrp_byte_t status_word;
	dhrp_byte_t next_rdata;

	function automatic dhrp_byte_t pick(input logic [15:0] r, input logic hi);
		pick = hi ? r[15:8] : r[7:0]; // see [R20]
	endfunction : pick

	// channel register space: A3 low
	function automatic logic chan_sel(input dhrp_addr_t a);
		chan_sel = !a[`DHRP_A3_BIT]; // see [R10]
	endfunction : chan_sel

	// mode on writes, status on reads
	function automatic logic gen_sel(input dhrp_addr_t a);
		gen_sel = a == `DHRP_GEN_SEL; // see [R10]
	endfunction : gen_sel

	assign rd_act = !BUS.cs_n && !BUS.rd_n; // see [R9]
	assign wr_act = !BUS.cs_n && !BUS.wr_n; // see [R9]
	// strobe end: active last cycle, inactive now
	assign rd_end = rd_q && !rd_act;
	assign wr_end = wr_q && !wr_act;
	assign is_gen = gen_sel(addr_q);
	assign chan = addr_q[2:1]; // see [R11]
	assign addr_wr = wr_end && chan_sel(addr_q) && !addr_q[`DHRP_A0_BIT]; // see [R11]
	assign cnt_wr = wr_end && chan_sel(addr_q) && addr_q[`DHRP_A0_BIT];
	assign status_word = 8'({3'b000, pending, done_flags}); // see [R6]

	// strobe history
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			rd_q <= 1'b0;
			wr_q <= 1'b0;
		end else begin
			rd_q <= rd_act;
			wr_q <= wr_act;
		end
	end

	// address latched while a strobe is low
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			addr_q <= '0;
		end else if (rd_act || wr_act) begin
			addr_q <= BUS.addr;
		end
	end

	// address registers, written at the end of the strobe
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			for (int i = 0; i < NCH; i++) begin
				xfer_address[i] <= '0;
			end
		end else if (addr_wr) begin
			if (byte_ptr) begin
				xfer_address[chan][15:8] <= BUS.wdata; // see [R8] see [R12]
			end else begin
				xfer_address[chan][7:0] <= BUS.wdata;
			end
		end
	end

	// count registers, cycle type in the top two bits
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			for (int i = 0; i < NCH; i++) begin
				xfer_count[i] <= '0;
			end
		end else if (cnt_wr) begin
			if (byte_ptr) begin
				xfer_count[chan][15:8] <= BUS.wdata; // see [R18]
			end else begin
				xfer_count[chan][7:0] <= BUS.wdata;
			end
		end
	end

	// mode register, write only
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			MODE <= `DHRP_MODE_RESET;
		end else if (wr_end && is_gen) begin
			MODE <= BUS.wdata; // see [R7]
		end
	end

	// byte pointer
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			byte_ptr <= 1'b0;
		end else if (wr_end && is_gen) begin
			byte_ptr <= 1'b0; // see [R13]
		end else if ((wr_end || rd_end) && chan_sel(addr_q)) begin
			byte_ptr <= !byte_ptr; // see [R12]
		end
	end

	// read mux, reserved addresses read zero
	always_comb begin
		next_rdata = '0;
		if (gen_sel(BUS.addr)) begin
			next_rdata = status_word; // see [R6]
		end else if (chan_sel(BUS.addr) && !BUS.addr[`DHRP_A0_BIT]) begin
			next_rdata = pick(xfer_address[BUS.addr[2:1]], byte_ptr); // see [R11]
		end else if (chan_sel(BUS.addr)) begin
			next_rdata = pick(xfer_count[BUS.addr[2:1]], byte_ptr);
		end
	end

	// read data stands one cycle after the strobe is seen
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			BUS.rdata <= '0;
		end else begin
			BUS.rdata <= rd_act ? next_rdata : '0; // see [R9]
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			BUS.rdata_oe <= 1'b0;
		end else begin
			BUS.rdata_oe <= rd_act;
		end
	end

	// count-done and reload-pending flags
	dhrp_status #(.NCH(NCH)) dhrp_status_inst (
		.clk(CLK),
		.reset_n(RESET_N),
		.count_done(COUNT_DONE),
		.status_read_end(rd_end && is_gen),
		.reload_start(RELOAD_START),
		.reload_finish(RELOAD_FINISH),
		.mode_write(wr_end && is_gen),
		.mode_reload_bit(BUS.wdata[`DHRP_MODE_RELOAD]),
		.count_done_flags(done_flags),
		.reload_pending(pending)
	);

	assign COUNT_DONE_FLAGS = done_flags;
	assign RELOAD_PENDING = pending;

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			XFER_ADDRESS[i*16 +: 16] = xfer_address[i];
			XFER_COUNT[i*16 +: 16] = xfer_count[i];
			CYCLE_TYPE[i*2 +: 2] = xfer_count[i][`DHRP_CNT_TYPE_HI:`DHRP_CNT_TYPE_LO];
		end
	end
endmodule : dhrp_device

/* File: verilog/dhrp_host.sv */
`include "dhrp_regs.svh"
module dhrp_host (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// avalon-mm slave
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// register port to device
	dhrp_if.host BUS
);
	import dhrp_pkg::*;

	dhrp_hstate_t state;
	logic cmd_wr;
	logic [3:0] cmd_addr;
	logic [7:0] cmd_wdata;
	logic [7:0] cmd_rdata;
	logic go;
	logic [31:0] next_readdata;

	assign go = AVS_WRITE && AVS_ADDRESS == `DHRP_CSR_CMD && AVS_WRITEDATA[`DHRP_CMD_GO];
	// no wait state, except a go write while busy stalls
	assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !(state == DHRP_H_IDLE || !go)
		? 1'b1 : 1'b0;

	always_comb begin
		next_readdata = '0;
		unique case (AVS_ADDRESS)
			`DHRP_CSR_CMD: next_readdata = {30'h0000_0000, cmd_wr, 1'b0};
			`DHRP_CSR_ADDR: next_readdata = {28'h000_0000, cmd_addr};
			`DHRP_CSR_WDATA: next_readdata = {24'h00_0000, cmd_wdata};
			`DHRP_CSR_RDATA: next_readdata = {24'h00_0000, cmd_rdata};
			`DHRP_CSR_STATE: next_readdata = {31'h0000_0000, state != DHRP_H_IDLE};
			default: next_readdata = '0;
		endcase
	end
	assign AVS_READDATA = next_readdata;

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			cmd_wr <= 1'b0;
			cmd_addr <= '0;
			cmd_wdata <= '0;
		end else if (AVS_WRITE && !AVS_WAITREQUEST) begin
			if (AVS_ADDRESS == `DHRP_CSR_CMD) begin
				cmd_wr <= AVS_WRITEDATA[`DHRP_CMD_WR];
			end else if (AVS_ADDRESS == `DHRP_CSR_ADDR) begin
				cmd_addr <= AVS_WRITEDATA[3:0];
			end else if (AVS_ADDRESS == `DHRP_CSR_WDATA) begin
				cmd_wdata <= AVS_WRITEDATA[7:0];
			end
		end
	end

	// select set up before and held past the strobe
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			state <= DHRP_H_IDLE;
			BUS.cs_n <= 1'b1;
			BUS.rd_n <= 1'b1;
			BUS.wr_n <= 1'b1;
			BUS.addr <= '0;
			BUS.wdata <= '0;
			cmd_rdata <= '0;
		end else begin
			unique case (state)
				DHRP_H_IDLE: if (go) begin
					state <= DHRP_H_SETUP;
					BUS.cs_n <= 1'b0;
					BUS.addr <= cmd_addr;
					BUS.wdata <= cmd_wdata;
				end
				DHRP_H_SETUP: begin
					state <= DHRP_H_STROBE;
					BUS.wr_n <= !cmd_wr;
					BUS.rd_n <= cmd_wr;
				end
				DHRP_H_STROBE: begin
					state <= DHRP_H_HOLD;
					BUS.wr_n <= 1'b1; // see [R15]
					BUS.rd_n <= 1'b1;
				end
				DHRP_H_HOLD: begin
					state <= DHRP_H_IDLE;
					BUS.cs_n <= 1'b1; // see [R15]
					// read data stands one cycle after the strobe
					if (!cmd_wr) begin
						cmd_rdata <= BUS.rdata;
					end
				end
			endcase
		end
	end
	// pairing, low byte first, reload wait and inhibit are software's duty
	// see [R14] see [R16] see [R5] see [R17] see [R19]
endmodule : dhrp_host

/* File: dv/dhrp_link_checker.sv */
module dhrp_link_checker (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// link signals
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rdata_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	property p_rd_oe; !cs_n && !rd_n |=> rdata_oe; endproperty
	a_rd_oe: assert property (p_rd_oe)
		else $error("read data not driven after read strobe");
	property p_oe_cause; rdata_oe |-> !$past(rd_n) && !$past(cs_n); endproperty
	a_oe_cause: assert property (p_oe_cause)
		else $error("read data driven without read strobe");
	property p_stat_zero; rdata_oe && addr == 4'h8 |-> rdata[7:5] == 3'h0; endproperty
	a_stat_zero: assert property (p_stat_zero)
		else $error("status top bits not zero");
	property p_resv; rdata_oe && addr[3] && addr[2:0] != 3'h0 |-> rdata == 8'h00; endproperty
	a_resv: assert property (p_resv)
		else $error("reserved address read not zero");
	property p_excl; rd_n || wr_n; endproperty
	a_excl: assert property (p_excl)
		else $error("both strobes low");
	property p_cs_steady; !rd_n || !wr_n |-> (!cs_n && !$past(cs_n)) ##1 !cs_n; endproperty
	a_cs_steady: assert property (p_cs_steady)
		else $error("select moved around strobe");
	property p_strobe_one; $fell(rd_n) || $fell(wr_n) |=> rd_n && wr_n; endproperty
	a_strobe_one: assert property (p_strobe_one)
		else $error("strobe longer than one cycle");
	property p_frame_end;
		$rose(rd_n) || $rose(wr_n) |-> ($stable(addr) && $stable(wdata)) ##1 cs_n;
	endproperty
	a_frame_end: assert property (p_frame_end)
		else $error("cycle not closed after strobe");
	property p_cs_go; $fell(cs_n) |-> (rd_n && wr_n) ##1 (!rd_n || !wr_n); endproperty
	a_cs_go: assert property (p_cs_go)
		else $error("strobe not one cycle after select");
endmodule : dhrp_link_checker

/* File: dv/dma_host_register_port_test.sv */
`include "dhrp_regs.svh"
module dma_host_register_port_test;
	timeunit 1ns;
	timeprecision 1ns;
	import dhrp_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] count_done = '0;
	logic reload_start = 1'b0;
	logic reload_finish = 1'b0;
	dhrp_byte_t mode;
	logic [63:0] xfer_address;
	logic [63:0] xfer_count;
	logic [7:0] cycle_type;
	logic [3:0] flags;
	logic pending;
	int fail_count = 0;
	int n_compared = 0;
	dhrp_if bus();
	always #50 clk = ~clk;
	dhrp_device dhrp_device_inst (.CLK(clk), .RESET_N(reset_n), .BUS(bus),
		.COUNT_DONE(count_done), .RELOAD_START(reload_start),
		.RELOAD_FINISH(reload_finish), .MODE(mode), .XFER_ADDRESS(xfer_address),
		.XFER_COUNT(xfer_count), .CYCLE_TYPE(cycle_type),
		.COUNT_DONE_FLAGS(flags), .RELOAD_PENDING(pending));
	dhrp_host dhrp_host_inst (.CLK(clk), .RESET_N(reset_n), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .BUS(bus));
	dhrp_link_checker dhrp_link_checker_inst (.CLK(clk), .RESET_N(reset_n),
		.cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n), .addr(bus.addr),
		.wdata(bus.wdata), .rdata(bus.rdata), .rdata_oe(bus.rdata_oe));
	task automatic final_report;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic avs(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (avs_waitrequest !== 1'b0) begin
			fail_count++;
			final_report();
		end else begin
			q = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			@(posedge clk);
		end
	endtask : avs
	task automatic lnk(input logic w, input dhrp_addr_t a, input dhrp_byte_t d,
		output dhrp_byte_t q);
		logic [31:0] r;
		int n;
		avs(1'b1, `DHRP_CSR_ADDR, 32'(a), r);
		avs(1'b1, `DHRP_CSR_WDATA, 32'(d), r);
		avs(1'b1, `DHRP_CSR_CMD, 32'({w, 1'b1}), r);
		n = 0;
		do begin
			avs(1'b0, `DHRP_CSR_STATE, '0, r);
			n++;
		end while (r[0] !== 1'b0 && n < 50);
		if (r[0] !== 1'b0) begin
			fail_count++;
			final_report();
		end else begin
			avs(1'b0, `DHRP_CSR_RDATA, '0, r);
			q = r[7:0];
		end
	endtask : lnk
	task automatic pulse(input logic [3:0] cd, input logic rs, input logic rf);
		count_done <= cd;
		reload_start <= rs;
		reload_finish <= rf;
		@(posedge clk);
		count_done <= '0;
		reload_start <= 1'b0;
		reload_finish <= 1'b0;
		@(posedge clk);
	endtask : pulse
	initial begin
		logic [15:0] v;
		logic [31:0] r;
		dhrp_byte_t lo;
		dhrp_byte_t hi;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		check(mode, 8'h00);
		lnk(1'b0, 4'h8, '0, lo);
		check(lo, 8'h00);
		for (int i = 0; i < 8; i++) begin
			v = 16'h1A05 + 16'(i) * 16'h2111;
			lnk(1'b1, 4'(i), v[7:0], lo);
			lnk(1'b1, 4'(i), v[15:8], lo);
		end
		for (int i = 0; i < 8; i++) begin
			v = 16'h1A05 + 16'(i) * 16'h2111;
			if (i[0]) begin
				check(xfer_count[16*(i/2)+:16], v);
				check(cycle_type[2*(i/2)+:2], v[15:14]);
			end else begin
				check(xfer_address[16*(i/2)+:16], v);
			end
			lnk(1'b0, 4'(i), '0, lo);
			lnk(1'b0, 4'(i), '0, hi);
			check({hi, lo}, v);
		end
		lnk(1'b1, 4'h0, 8'h55, lo);
		lnk(1'b1, 4'h8, 8'h8F, lo);
		check(mode, 8'h8F);
		lnk(1'b1, 4'h0, 8'hAA, lo);
		lnk(1'b1, 4'h0, 8'h66, lo);
		check(xfer_address[15:0], 16'h66AA);
		pulse(4'h5, 1'b1, 1'b0);
		check(flags, 4'h5);
		lnk(1'b0, 4'h8, '0, lo);
		check(lo, 8'h15);
		lnk(1'b0, 4'h8, '0, lo);
		check(lo, 8'h10);
		check(flags, 4'h0);
		pulse(4'h0, 1'b0, 1'b1);
		lnk(1'b0, 4'h8, '0, lo);
		check(lo, 8'h00);
		pulse(4'h0, 1'b1, 1'b0);
		check(pending, 1'b1);
		lnk(1'b1, 4'h8, 8'h0F, lo);
		check(pending, 1'b0);
		lnk(1'b1, 4'h9, 8'hFF, lo);
		check(mode, 8'h0F);
		lnk(1'b0, 4'h9, '0, lo);
		check(lo, 8'h00);
		// mid-run reset with pointer, flags and pending set
		lnk(1'b1, 4'h2, 8'h77, lo);
		pulse(4'h3, 1'b1, 1'b0);
		check(flags, 4'h3);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		check(mode, 8'h00);
		check(pending, 1'b0);
		lnk(1'b0, 4'h8, '0, lo);
		check(lo, 8'h00);
		lnk(1'b1, 4'h2, 8'h12, lo);
		lnk(1'b1, 4'h2, 8'h34, lo);
		check(xfer_address[31:16], 16'h3412);
		avs(1'b0, 8'h20, '0, r);
		check(r, '0);
		final_report();
	end
endmodule : dma_host_register_port_test
